// ---- include/rwic_pkg.sv ----
// shared constants for reset, watchdog and interrupt control
package rwic_pkg;
  // register addresses
  localparam logic [12:0] WDOG_RESTART_ADDR = 13'h1FF0;
  localparam logic [12:0] TMR_CTRL_ADDR = 13'h0040;
  localparam logic [12:0] ASC_CTRL_ADDR = 13'h0041;
  localparam logic [12:0] ASC_RATE_ADDR = 13'h0042;
  localparam logic [12:0] SYNC_CTRL_ADDR = 13'h0043;
  localparam logic [12:0] TMR_STAT_ADDR = 13'h0044;
  localparam logic [12:0] ASC_STAT_ADDR = 13'h0045;
  localparam logic [12:0] SYNC_STAT_ADDR = 13'h0046;
  localparam logic [12:0] CORE_STAT_ADDR = 13'h0047;
  // vectors
  localparam logic [12:0] VEC_RESET = 13'h1FFE;
  localparam logic [12:0] VEC_TRAP = 13'h1FFC;
  localparam logic [12:0] VEC_EXT = 13'h1FFA;
  localparam logic [12:0] VEC_TMR = 13'h1FF8;
  localparam logic [12:0] VEC_ASC = 13'h1FF6;
  localparam logic [12:0] VEC_SYNC = 13'h1FF4;
  // reset values
  localparam logic [15:0] TIMER_RESET_VAL = 16'hFFFC;
  localparam logic [12:0] SP_RESET_VAL = 13'h00FF;
  localparam logic [6:0] ASC_STAT_RESET = 7'h03;
  // timing
  localparam int POR_DELAY_CYC = 4064;
  localparam int WDOG_STAGES = 18;
  localparam int CYC_DIV = 2;
  // field positions
  localparam int WDOG_CLR_BIT = 0;
  localparam int ASC_TXE = 0;
  localparam int ASC_TXC = 1;
  localparam int ASC_RXF = 2;
  localparam int ASC_IDLE = 3;
  localparam int ASC_OVR = 4;
  localparam int ASC_TIE = 2;
  localparam int ASC_ASYNC_TX_DONE_IRQ_ENABLE = 3;
  localparam int ASC_RIE = 4;
  localparam int ASC_ASYNC_IDLE_IRQ_ENABLE = 5;
  localparam int SYNC_IE = 1;
  typedef enum logic [2:0] {
    C_DELAY = 3'b001,
    C_HOLD = 3'b010,
    C_RUN = 3'b011,
    C_STOP = 3'b100,
    C_WAIT = 3'b101
  } core_t;
endpackage : rwic_pkg

// ---- include/wdog_if.sv ----
// watchdog control and count between the controller and the counter
`timescale 1ns/1ps
interface wdog_if #(parameter int W = rwic_pkg::WDOG_STAGES);
  logic run;
  logic clear;
  logic tick;
  logic expire;
  logic [W-1:0] count;
  modport ctl(output run, output clear, output tick, input expire, input count);
  modport cnt(input run, input clear, input tick, output expire, output count);
endinterface : wdog_if

// ---- verilog/wdog_counter.sv ----
// synchronous watchdog counter with wrap detection
`timescale 1ns/1ps
module wdog_counter #(
  parameter int W = rwic_pkg::WDOG_STAGES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  wdog_if.cnt wd
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } wst_t;
  wst_t r;
  wst_t n;

  always_comb begin
    n = r;
    if (wd.clear || !wd.run) begin
      n.cnt = '0;
    end else if (wd.tick) begin
      n.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign wd.count = r.cnt;
  assign wd.expire = wd.run && wd.tick && (&r.cnt);

  a_wd_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (wd.clear || !wd.run) |=> wd.count == '0) else $error("watchdog not cleared");
  a_wd_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (wd.run && !wd.clear && wd.tick) |=> wd.count == W'($past(wd.count) + 1))
    else $error("watchdog did not advance");
endmodule : wdog_counter

// ---- verilog/reset_watchdog_interrupt_control.sv ----
// reset sequencing, watchdog control and interrupt entry for the processor core
// Behaviour
// - after power-up stay in reset for 4064 processor cycles
// - reset pin still low after the delay holds reset; release on next cycle
// - 18-stage watchdog expiry resets the whole device like the reset pin, without the start-up delay
// - writing zero to bit 0 of the restart location restarts the watchdog
// - watchdog keeps counting in wait; software must leave wait to restart it
// - watchdog cleared in stop; interrupt wake lets it count through the delay
// - watchdog inactive in self-test mode
// - reset clears timer prescaler, enables, output bits; counter loads FFFC
// - reset clears directions, watchdog, latches; sets mask; stack pointer 00FF
// - reset disables async serial, clears its controls, sets empty and done flags
// - reset disables sync serial, slave mode, clears its enable and flags
// - a zero enable blocks the request but the flag still sets
// - enabled pending request taken at instruction end; mask set, vector fetched
// - return restores mask from the stacked copy
// - any reset sets the mask and vectors through 1FFE
// - software trap taken regardless of mask, vector 1FFC
// - timer, async and sync serial flags share vectors 1FF8, 1FF6, 1FF4
// - stop halts the oscillator until external request or reset
// - wait stops core clocks; reset or any interrupt ends it
// - external request on falling edge, optionally low level, vector 1FFA
// - external latch cleared at entry; one further edge is held
`timescale 1ns/1ps
module reset_watchdog_interrupt_control #(
  parameter int POR_CYCLES = rwic_pkg::POR_DELAY_CYC,
  parameter int WDOG_STAGES = rwic_pkg::WDOG_STAGES,
  parameter bit STOP_ENABLE = 1'b1,
  parameter bit LEVEL_TRIG = 1'b1,
  parameter bit WDOG_PRESENT = 1'b1,
  parameter logic [7:0] SELF_TEST_CODE = 8'h5A // arbitrary value
) (
  // clock and power-on reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // pins
  input wire logic RESET_PIN_N,
  input wire logic IRQ_PIN_N,
  input wire logic SELF_TEST,
  // core handshake
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic STOP_EXEC,
  input wire logic WAIT_EXEC,
  input wire logic RTI_EXEC,
  input wire logic RTI_MASK_BIT,
  input wire logic MASK_CLEAR,
  output logic VECTOR_FETCH,
  output logic [12:0] VECTOR_ADDR,
  output logic IRQ_MASK,
  output logic CORE_RESET,
  output logic OSC_RUN,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic [15:0] TMR_LOAD_VAL,
  output logic [12:0] SP_LOAD_VAL,
  // peripheral events and controls
  input wire logic [2:0] TMR_EVT,
  input wire logic [6:0] ASC_EVT,
  input wire logic [2:0] SYNC_EVT,
  output logic [4:0] TMR_CTRL,
  output logic [7:0] ASC_CTRL,
  output logic [7:0] ASC_RATE,
  output logic [2:0] SYNC_CTRL,
  // register port
  input wire logic [12:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);
  localparam int DLY_W = $clog2(POR_CYCLES);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(POR_CYCLES - 1);
  localparam logic [3:0] DIV_LAST = 4'(rwic_pkg::CYC_DIV - 1);

  typedef struct packed {
    rwic_pkg::core_t st;
    logic [DLY_W-1:0] dly;
    logic [3:0] div;
    logic [2:0] rsy;
    logic rf;
    logic [2:0] isy;
    logic irf;
    logic [2:0] tsy;
    logic tf;
    logic wake;
    logic ext;
    logic mask;
    logic take;
    logic [12:0] vec;
    logic core_rst;
    logic [4:0] tctl;
    logic [7:0] actl;
    logic [7:0] arate;
    logic [2:0] sctl;
    logic [2:0] tflg;
    logic [6:0] aflg;
    logic [2:0] sflg;
    logic [7:0] rdata;
  } regs_t;

  localparam regs_t R0 = '{st: rwic_pkg::C_DELAY, aflg: rwic_pkg::ASC_STAT_RESET, mask: 1'b1,
    core_rst: 1'b1, rsy: 3'h7, rf: 1'b1, isy: 3'h7, irf: 1'b1, default: '0};

  regs_t r;
  regs_t n;
  logic cyc_en;
  logic irq_fall;
  logic ext_set;
  logic ext_clr;
  logic rst_act;
  logic tmr_req;
  logic asc_req;
  logic sync_req;
  logic hw_req;
  logic wd_restart;
  logic [12:0] hw_vec;

  wdog_if #(.W(WDOG_STAGES)) wd();

  wdog_counter #(.W(WDOG_STAGES)) u_wdog (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wd(wd)
  );

  // processor cycle enable; the start-up delay, reset release and watchdog count these, the pin filters count clocks
  assign cyc_en = (r.div == DIV_LAST);

  assign tmr_req = |(r.tflg & r.tctl[2:0]);
  assign asc_req = (r.aflg[rwic_pkg::ASC_TXE] & r.actl[rwic_pkg::ASC_TIE])
    | (r.aflg[rwic_pkg::ASC_TXC] & r.actl[rwic_pkg::ASC_ASYNC_TX_DONE_IRQ_ENABLE])
    | ((r.aflg[rwic_pkg::ASC_RXF] | r.aflg[rwic_pkg::ASC_OVR]) & r.actl[rwic_pkg::ASC_RIE])
    | (r.aflg[rwic_pkg::ASC_IDLE] & r.actl[rwic_pkg::ASC_ASYNC_IDLE_IRQ_ENABLE]);
  assign sync_req = r.sctl[rwic_pkg::SYNC_IE] & (|r.sflg[1:0]);
  assign hw_req = r.ext | tmr_req | asc_req | sync_req;
  // fixed priority among the shared vectors
  assign hw_vec = r.ext ? rwic_pkg::VEC_EXT : tmr_req ? rwic_pkg::VEC_TMR :
    asc_req ? rwic_pkg::VEC_ASC : rwic_pkg::VEC_SYNC;

  assign rst_act = (r.st == rwic_pkg::C_HOLD) || (r.st == rwic_pkg::C_DELAY && !r.wake);
  assign wd_restart = WR && ADDR == rwic_pkg::WDOG_RESTART_ADDR && !WDATA[rwic_pkg::WDOG_CLR_BIT];

  // counts in run and wait, and through an interrupt wake from stop
  assign wd.run = WDOG_PRESENT && !r.tf && (r.st == rwic_pkg::C_RUN || r.st == rwic_pkg::C_WAIT
    || (r.st == rwic_pkg::C_DELAY && r.wake));
  assign wd.clear = wd_restart || rst_act;
  assign wd.tick = cyc_en;

  always_comb begin
    n = r;
    n.take = 1'b0;
    n.rdata = 8'h00;
    ext_clr = 1'b0;
    n.div = cyc_en ? 4'h0 : r.div + 4'h1;
    n.rsy = {r.rsy[1:0], RESET_PIN_N};
    n.isy = {r.isy[1:0], IRQ_PIN_N};
    n.tsy = {r.tsy[1:0], SELF_TEST};
    if (r.rsy[1] == r.rsy[2]) begin
      n.rf = r.rsy[2];
    end
    if (r.isy[1] == r.isy[2]) begin
      n.irf = r.isy[2];
    end
    if (r.tsy[1] == r.tsy[2]) begin
      n.tf = r.tsy[2];
    end
    irq_fall = r.irf & ~n.irf;
    // level mode keeps the latch armed while the line stays low
    ext_set = irq_fall | (LEVEL_TRIG & ~r.irf);
    // status flags: the event wins over a write-one clear
    n.tflg = (r.tflg & ~((WR && ADDR == rwic_pkg::TMR_STAT_ADDR) ? WDATA[2:0] : 3'h0)) | TMR_EVT;
    n.aflg = (r.aflg & ~((WR && ADDR == rwic_pkg::ASC_STAT_ADDR) ? WDATA[6:0] : 7'h00)) | ASC_EVT;
    n.sflg = (r.sflg & ~((WR && ADDR == rwic_pkg::SYNC_STAT_ADDR) ? WDATA[2:0] : 3'h0)) | SYNC_EVT;
    if (WR) begin
      unique case (ADDR)
        rwic_pkg::TMR_CTRL_ADDR: n.tctl = WDATA[4:0];
        rwic_pkg::ASC_CTRL_ADDR: n.actl = WDATA;
        rwic_pkg::ASC_RATE_ADDR: n.arate = WDATA;
        rwic_pkg::SYNC_CTRL_ADDR: n.sctl = WDATA[2:0];
        default: n.rdata = 8'h00;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        rwic_pkg::WDOG_RESTART_ADDR: n.rdata = SELF_TEST_CODE;
        rwic_pkg::TMR_CTRL_ADDR: n.rdata = {3'h0, r.tctl};
        rwic_pkg::ASC_CTRL_ADDR: n.rdata = r.actl;
        rwic_pkg::ASC_RATE_ADDR: n.rdata = r.arate;
        rwic_pkg::SYNC_CTRL_ADDR: n.rdata = {5'h00, r.sctl};
        rwic_pkg::TMR_STAT_ADDR: n.rdata = {5'h00, r.tflg};
        rwic_pkg::ASC_STAT_ADDR: n.rdata = {1'b0, r.aflg};
        rwic_pkg::SYNC_STAT_ADDR: n.rdata = {5'h00, r.sflg};
        rwic_pkg::CORE_STAT_ADDR: n.rdata = {2'h0, r.st, r.wake, r.ext, r.mask};
        default: n.rdata = 8'h00;
      endcase
    end
    if (RTI_EXEC) begin
      n.mask = RTI_MASK_BIT;
    end else if (MASK_CLEAR) begin
      n.mask = 1'b0;
    end
    unique case (r.st)
      rwic_pkg::C_DELAY: begin
        if (!r.rf) begin
          n.wake = 1'b0;
        end
        if (cyc_en) begin
          n.dly = r.dly + DLY_W'(1);
          if (r.dly == DLY_LAST) begin
            n.dly = '0;
            n.st = r.wake ? rwic_pkg::C_RUN : rwic_pkg::C_HOLD;
          end
        end
      end
      rwic_pkg::C_HOLD: begin
        if (r.rf && cyc_en) begin
          n.st = rwic_pkg::C_RUN;
          n.take = 1'b1;
          n.vec = rwic_pkg::VEC_RESET;
        end
      end
      rwic_pkg::C_RUN: begin
        if (!r.rf || wd.expire) begin
          n.st = rwic_pkg::C_HOLD;
        end else if (INSTR_DONE) begin
          if (TRAP_EXEC) begin
            n.take = 1'b1;
            n.vec = rwic_pkg::VEC_TRAP;
            n.mask = 1'b1;
          end else if (hw_req && !r.mask) begin
            n.take = 1'b1;
            n.vec = hw_vec;
            n.mask = 1'b1;
            ext_clr = r.ext;
          end else if (STOP_EXEC) begin
            // without the stop option the stop instruction acts as wait
            n.st = STOP_ENABLE ? rwic_pkg::C_STOP : rwic_pkg::C_WAIT;
            n.mask = 1'b0;
          end else if (WAIT_EXEC) begin
            n.st = rwic_pkg::C_WAIT;
            n.mask = 1'b0;
          end
        end
      end
      rwic_pkg::C_WAIT: begin
        if (!r.rf || wd.expire) begin
          n.st = rwic_pkg::C_HOLD;
        end else if (hw_req && !r.mask) begin
          n.st = rwic_pkg::C_RUN;
          n.take = 1'b1;
          n.vec = hw_vec;
          n.mask = 1'b1;
          ext_clr = r.ext;
        end
      end
      rwic_pkg::C_STOP: begin
        // either exit restarts the oscillator, so both pass the start-up delay
        if (!r.rf) begin
          n.st = rwic_pkg::C_DELAY;
          n.wake = 1'b0;
          n.dly = '0;
        end else if (r.ext) begin
          n.st = rwic_pkg::C_DELAY;
          n.wake = 1'b1;
          n.dly = '0;
        end
      end
      default: n.st = rwic_pkg::C_HOLD;
    endcase
    n.ext = ext_set | (r.ext & ~ext_clr);
    if (rst_act) begin
      n.tctl = 5'h00;
      n.actl = 8'h00;
      n.arate = 8'h00;
      n.aflg = rwic_pkg::ASC_STAT_RESET;
      n.sctl = 3'h0;
      n.sflg = 3'h0;
      n.tflg = 3'h0;
      n.ext = 1'b0;
      n.mask = 1'b1;
    end
    n.core_rst = rst_act;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      r <= R0;
    end else begin
      r <= n;
    end
  end

  assign VECTOR_FETCH = r.take;
  assign VECTOR_ADDR = r.vec;
  assign IRQ_MASK = r.mask;
  assign CORE_RESET = r.core_rst;
  assign OSC_RUN = (r.st != rwic_pkg::C_STOP);
  assign CPU_CLK_EN = cyc_en && r.st == rwic_pkg::C_RUN;
  assign PERIPH_CLK_EN = cyc_en && (r.st == rwic_pkg::C_RUN || r.st == rwic_pkg::C_WAIT);
  // loaded by the timer and core while CORE_RESET is high
  assign TMR_LOAD_VAL = rwic_pkg::TIMER_RESET_VAL;
  assign SP_LOAD_VAL = rwic_pkg::SP_RESET_VAL;
  assign TMR_CTRL = r.tctl;
  assign ASC_CTRL = r.actl;
  assign ASC_RATE = r.arate;
  assign SYNC_CTRL = r.sctl;
  assign RDATA = r.rdata;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_irq_fall;
    (r.irf && !rst_act) ##1 !r.irf;
  endsequence
  sequence s_stop_wake;
    r.st == rwic_pkg::C_STOP && r.ext && r.rf;
  endsequence

  a_delay_runs: assert property ((r.st == rwic_pkg::C_DELAY && r.dly != DLY_LAST)
    |=> r.st == rwic_pkg::C_DELAY) else $error("start-up delay cut short");
  a_delay_ends: assert property ((r.st == rwic_pkg::C_DELAY && cyc_en && r.dly == DLY_LAST)
    |=> r.st != rwic_pkg::C_DELAY) else $error("start-up delay overran");
  a_pin_holds: assert property ((r.st == rwic_pkg::C_HOLD && !r.rf)
    |=> r.st == rwic_pkg::C_HOLD && CORE_RESET) else $error("reset released while pin low");
  a_reset_vector: assert property ((r.st == rwic_pkg::C_HOLD && r.rf && cyc_en)
    |=> r.take && r.vec == rwic_pkg::VEC_RESET && r.mask) else $error("bad reset vector");
  a_wd_expiry: assert property ((wd.expire && r.rf && r.st == rwic_pkg::C_RUN)
    |=> r.st == rwic_pkg::C_HOLD ##1 CORE_RESET) else $error("watchdog expiry ignored");
  a_stop_wd_off: assert property (r.st == rwic_pkg::C_STOP |-> !wd.run && !OSC_RUN)
    else $error("watchdog or oscillator running in stop");
  a_test_wd_off: assert property (r.tf |-> !wd.run) else $error("watchdog runs in self-test");
  a_flag_sets: assert property ((TMR_EVT[0] && !rst_act) |=> r.tflg[0])
    else $error("flag missed its event");
  a_trap_taken: assert property ((r.st == rwic_pkg::C_RUN && r.rf && !wd.expire && INSTR_DONE
    && TRAP_EXEC) |=> r.take && r.vec == rwic_pkg::VEC_TRAP && r.mask) else $error("trap not taken");
  a_irq_gated: assert property ((r.take && r.vec != rwic_pkg::VEC_TRAP && r.vec != rwic_pkg::VEC_RESET)
    |-> !$past(r.mask)) else $error("interrupt taken while masked");
  a_rti_mask: assert property ((RTI_EXEC && r.st == rwic_pkg::C_RUN && r.rf && !wd.expire
    && !INSTR_DONE) |=> r.mask == $past(RTI_MASK_BIT)) else $error("mask not restored");
  a_ext_latch: assert property (s_irq_fall |-> r.ext) else $error("edge not latched");
  a_stop_wake: assert property (s_stop_wake |=> r.st == rwic_pkg::C_DELAY && r.wake)
    else $error("stop not left on request");
  a_wait_exit: assert property ((r.st == rwic_pkg::C_WAIT && hw_req && !r.mask && r.rf
    && !wd.expire) |=> r.st == rwic_pkg::C_RUN && r.take) else $error("wait not left");
endmodule : reset_watchdog_interrupt_control

// ---- test/ext_pins.sv ----
// far-side model: external reset circuit and pulled-up request line
`timescale 1ns/1ps
module ext_pins (
  // clock
  input wire logic clk,
  // pins, pulled up while nobody pulls them low
  output logic reset_n,
  output logic irq_n
);
  initial begin
    reset_n = 1'b1;
    irq_n = 1'b1;
  end
  // short reset pulses are stretched so the pin filter always sees them
  // three clocks make one and a half processor cycles
  task automatic reset_pulse(input int n);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat ((n < 3) ? 3 : n) @(posedge clk);
    reset_n <= 1'b1;
  endtask : reset_pulse
  // callers may give a further falling edge before the service ends; the latch holds only one
  task automatic irq_set(input logic v, input int n);
    @(posedge clk);
    irq_n <= v;
    repeat (n) @(posedge clk);
  endtask : irq_set
endmodule : ext_pins

// ---- test/reset_watchdog_interrupt_control_tb.sv ----
// self-checking bench for reset, watchdog and interrupt control
`timescale 1ns/1ps
module reset_watchdog_interrupt_control_tb;
  localparam int POR = 8;
  localparam int LIMIT = 20000;
  localparam logic [7:0] STC = 8'h3C; // arbitrary self-test code
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic st = 1'b1;
  logic idone = 1'b0, trap = 1'b0, stp = 1'b0, wt = 1'b0, rti_e = 1'b0, rti_b = 1'b0, mclr = 1'b0;
  logic wr = 1'b0, rd = 1'b0;
  logic [2:0] tev = 3'h0, sev = 3'h0;
  logic [6:0] aev = 7'h00;
  logic [12:0] addr = 13'h0000;
  logic [7:0] wdata = 8'h00;
  logic rpin, ipin, vf, msk, crst, osc, cpu_en, per_en;
  logic [12:0] va, spl;
  logic [15:0] tlv;
  logic [4:0] tctl;
  logic [7:0] actl, arate, rdata;
  logic [2:0] sctl;
  logic [15:0] seed = 16'hF189;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  ext_pins p (.clk(clk), .reset_n(rpin), .irq_n(ipin));
  reset_watchdog_interrupt_control #(.POR_CYCLES(POR), .WDOG_STAGES(6), .SELF_TEST_CODE(STC)) uut (
    .REF_CLK(clk), .RST_N(rst_n), .RESET_PIN_N(rpin), .IRQ_PIN_N(ipin), .SELF_TEST(st),
    .INSTR_DONE(idone), .TRAP_EXEC(trap), .STOP_EXEC(stp), .WAIT_EXEC(wt), .RTI_EXEC(rti_e),
    .RTI_MASK_BIT(rti_b), .MASK_CLEAR(mclr), .VECTOR_FETCH(vf), .VECTOR_ADDR(va), .IRQ_MASK(msk),
    .CORE_RESET(crst), .OSC_RUN(osc), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .TMR_LOAD_VAL(tlv),
    .SP_LOAD_VAL(spl), .TMR_EVT(tev), .ASC_EVT(aev), .SYNC_EVT(sev), .TMR_CTRL(tctl), .ASC_CTRL(actl),
    .ASC_RATE(arate), .SYNC_CTRL(sctl), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  // reference priority: trap, external, timer, async, sync
  function automatic logic [12:0] expv(input int pend);
    logic [12:0] vt [5] = '{rwic_pkg::VEC_TRAP, rwic_pkg::VEC_EXT, rwic_pkg::VEC_TMR,
                            rwic_pkg::VEC_ASC, rwic_pkg::VEC_SYNC};
    logic [12:0] r;
    r = 13'h0000;
    for (int i = 4; i >= 0; i--) begin
      if (pend[i]) r = vt[i];
    end
    return r;
  endfunction : expv
  task automatic tally(input logic ok, input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : tally
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    tally(g === e, g, e);
  endtask : chk_word
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tally(g === e, {8'h00, g}, {8'h00, e});
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    tally(g === e, {15'h0000, g}, {15'h0000, e});
  endtask : chk_bit
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic wreg(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rreg
  task automatic instr(input logic t, input logic s, input logic w);
    @(posedge clk);
    idone <= 1'b1;
    trap <= t;
    stp <= s;
    wt <= w;
    @(posedge clk);
    idone <= 1'b0;
    trap <= 1'b0;
    stp <= 1'b0;
    wt <= 1'b0;
  endtask : instr
  task automatic mask_op(input logic m, input logic r, input logic b);
    @(posedge clk);
    mclr <= m;
    rti_e <= r;
    rti_b <= b;
    @(posedge clk);
    mclr <= 1'b0;
    rti_e <= 1'b0;
  endtask : mask_op
  // source 0 is the request pin, 1..3 the peripheral event pulses
  task automatic evt(input int i);
    if (i == 0) begin
      p.irq_set(1'b0, 3);
      p.irq_set(1'b1, 0);
    end
    @(posedge clk);
    tev <= {2'b00, i == 1};
    aev <= {6'h00, i == 2};
    sev <= {2'b00, i == 3};
    @(posedge clk);
    tev <= 3'h0;
    aev <= 7'h00;
    sev <= 3'h0;
    repeat (4) @(posedge clk);
  endtask : evt
  // e of zero means no vector may be fetched in the window
  task automatic watch(input logic [12:0] e, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (vf === 1'b1 && !seen) begin
        seen = 1'b1;
        chk_word({3'h0, va}, {3'h0, e});
        chk_bit(msk, 1'b1);
      end
    end
    if (!seen && e !== 13'h0000) chk_word(16'h0000, {3'h0, e});
  endtask : watch
  task automatic reset_vals();
    logic [7:0] d;
    chk_bit(crst, 1'b0);
    chk_bit(msk, 1'b1);
    chk_word(tlv, rwic_pkg::TIMER_RESET_VAL);
    chk_word({3'h0, spl}, {3'h0, rwic_pkg::SP_RESET_VAL});
    chk_byte({3'h0, tctl}, 8'h00);
    chk_byte(actl, 8'h00);
    chk_byte(arate, 8'h00);
    chk_byte({5'h00, sctl}, 8'h00);
    rreg(rwic_pkg::ASC_STAT_ADDR, d);
    chk_byte(d, {1'b0, rwic_pkg::ASC_STAT_RESET});
    rreg(rwic_pkg::CORE_STAT_ADDR, d);
    chk_byte(d & 8'h3B, {2'b00, rwic_pkg::C_RUN, 3'b001});
  endtask : reset_vals
  // counts cycles to the reset vector; lo is the earliest legal fetch
  task automatic boot(input int lo);
    int n;
    n = 0;
    while (vf !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_word({3'h0, va}, {3'h0, rwic_pkg::VEC_RESET});
    chk_bit(crst, 1'b1);
    chk_bit(n >= lo && n < 400, 1'b1);
    repeat (3) @(negedge clk);
    reset_vals();
  endtask : boot
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      results();
    end
  end
  initial begin
    int n;
    int c;
    logic [7:0] d;
    static logic [12:0] ca [4] = '{13'h0000, rwic_pkg::TMR_CTRL_ADDR, rwic_pkg::ASC_CTRL_ADDR,
                                   rwic_pkg::SYNC_CTRL_ADDR};
    static logic [12:0] sa [4] = '{13'h0000, rwic_pkg::TMR_STAT_ADDR, rwic_pkg::ASC_STAT_ADDR,
                                   rwic_pkg::SYNC_STAT_ADDR};
    static logic [7:0] ce [4] = '{8'h00, 8'h01, 8'h04, 8'h02};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    boot(2 * POR);
    rreg(rwic_pkg::WDOG_RESTART_ADDR, d);
    chk_byte(d, STC);
    rreg(13'h0100, d);
    chk_byte(d, 8'h00);
    done("power_up");
    for (int i = 0; i < 4; i++) begin
      mask_op(1'b1, 1'b0, 1'b0);
      evt(i);
      if (i > 0) begin
        instr(1'b0, 1'b0, 1'b0);
        watch(13'h0000, 4);
        wreg(ca[i], ce[i]);
        watch(13'h0000, 4);
      end
      instr(1'b0, 1'b0, 1'b0);
      watch(expv(2 << i), 4);
      wreg(sa[i], 8'hFF);
      wreg(ca[i], 8'h00);
    end
    instr(1'b1, 1'b0, 1'b0);
    watch(expv(1), 4);
    for (int b = 0; b < 3; b++) begin
      mask_op(1'b0, 1'b1, b[0]);
      @(negedge clk);
      chk_bit(msk, b[0]);
    end
    done("sources");
    wreg(rwic_pkg::TMR_CTRL_ADDR, 8'h01);
    evt(1);
    evt(0);
    instr(1'b0, 1'b0, 1'b0);
    watch(expv(6), 4);
    mask_op(1'b1, 1'b0, 1'b0);
    instr(1'b0, 1'b0, 1'b0);
    watch(expv(4), 4);
    wreg(rwic_pkg::TMR_STAT_ADDR, 8'hFF);
    wreg(rwic_pkg::TMR_CTRL_ADDR, 8'h00);
    p.irq_set(1'b0, 4);
    mask_op(1'b1, 1'b0, 1'b0);
    instr(1'b0, 1'b0, 1'b0);
    watch(rwic_pkg::VEC_EXT, 4);
    p.irq_set(1'b1, 4);
    mask_op(1'b1, 1'b0, 1'b0);
    instr(1'b0, 1'b0, 1'b0);
    watch(rwic_pkg::VEC_EXT, 4);
    evt(0);
    evt(0);
    mask_op(1'b1, 1'b0, 1'b0);
    instr(1'b0, 1'b0, 1'b0);
    watch(rwic_pkg::VEC_EXT, 4);
    mask_op(1'b1, 1'b0, 1'b0);
    instr(1'b0, 1'b0, 1'b0);
    watch(13'h0000, 4);
    done("external");
    wreg(rwic_pkg::SYNC_CTRL_ADDR, 8'h02);
    instr(1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    n = 0;
    c = 0;
    repeat (10) begin
      @(negedge clk);
      if (cpu_en === 1'b1) n++;
      if (per_en === 1'b1) c++;
    end
    chk_bit(n == 0 && c > 0, 1'b1);
    // bare pulse: wait answers within two clocks, before evt would return
    @(posedge clk);
    sev <= 3'h1;
    @(posedge clk);
    sev <= 3'h0;
    watch(rwic_pkg::VEC_SYNC, 8);
    wreg(rwic_pkg::SYNC_STAT_ADDR, 8'hFF);
    wreg(rwic_pkg::SYNC_CTRL_ADDR, 8'h00);
    instr(1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clk);
    chk_bit(osc, 1'b0);
    watch(13'h0000, 10);
    evt(0);
    n = 0;
    while (osc !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk_bit(osc, 1'b1);
    repeat (2 * POR + 6) @(posedge clk);
    instr(1'b0, 1'b0, 1'b0);
    watch(rwic_pkg::VEC_EXT, 4);
    done("low_power");
    seed = lfsr(seed);
    wreg(rwic_pkg::ASC_RATE_ADDR, seed[7:0] | 8'h01);
    wreg(rwic_pkg::TMR_CTRL_ADDR, seed[15:8] | 8'h01);
    @(negedge clk);
    chk_byte(arate, seed[7:0] | 8'h01);
    n = 20 + int'(seed[3:0]);
    fork
      p.reset_pulse(n);
    join_none
    boot(n);
    done("pin_reset");
    @(posedge clk);
    st <= 1'b0;
    repeat (3) begin
      watch(13'h0000, 80);
      wreg(rwic_pkg::WDOG_RESTART_ADDR, 8'h00);
    end
    wreg(rwic_pkg::WDOG_RESTART_ADDR, 8'h01);
    boot(100);
    wreg(rwic_pkg::WDOG_RESTART_ADDR, 8'h00);
    instr(1'b0, 1'b0, 1'b1);
    boot(100);
    @(posedge clk);
    st <= 1'b1;
    watch(13'h0000, 300);
    done("watchdog");
    results();
  end
endmodule : reset_watchdog_interrupt_control_tb
